// ### core/pmpmc_pkg.sv
// Purpose: Constants and types for the PHY main-page mode control register set.
// Assumes: Management requests come from MAC logic on the same 20 MHz clock.
// Notes: Indices are 5-bit management register numbers, data is 16 bits.
// How it works
// - Bit 15 starts soft reset, self-clears.
// - Bit 14 selects digital loopback, resets zero.
// - Manual speed {6,13} and duplex bit 8.
// - Bit 12 enables autoneg, overrides manual bits.
// - Bit 11 enters power down, clear exits.
// - Bit 9 restarts autoneg, self-clears.
// - Bit 6 read-only, reads one.
// - Indices 0-15 identical on pages 0-2.
// - Index 31 is page access register.
// - Index 25 mask, 26 status, 27 reserved.
// - Index 20, 21 are readable event counters.
// - Index 28 auxiliary, 29-30 LED registers.
// - Pages 1-2 redirect 16-30; zero restores main.
// - Reached only via MAC management access port.
package pmpmc_pkg;

  // Register indices.
  localparam logic [4:0] PMPMC_IDX_MODE   = 5'h00;
  localparam logic [4:0] PMPMC_IDX_EXTLO  = 5'h10;
  localparam logic [4:0] PMPMC_IDX_FCCNT  = 5'h14;
  localparam logic [4:0] PMPMC_IDX_LDCNT  = 5'h15;
  localparam logic [4:0] PMPMC_IDX_IMASK  = 5'h19;
  localparam logic [4:0] PMPMC_IDX_ISTAT  = 5'h1a;
  localparam logic [4:0] PMPMC_IDX_RSVD   = 5'h1b;
  localparam logic [4:0] PMPMC_IDX_AUX    = 5'h1c;
  localparam logic [4:0] PMPMC_IDX_LEDSEL = 5'h1d;
  localparam logic [4:0] PMPMC_IDX_LEDBEH = 5'h1e;
  localparam logic [4:0] PMPMC_IDX_PAGE   = 5'h1f;

  // Page codes written to the page access register.
  localparam logic [15:0] PMPMC_PAGE_MAIN = 16'h0000;
  localparam logic [15:0] PMPMC_PAGE_EXT1 = 16'h0001;
  localparam logic [15:0] PMPMC_PAGE_EXT2 = 16'h0002;
  localparam logic [1:0]  PMPMC_PSEL_MAIN = 2'h0;
  localparam logic [1:0]  PMPMC_PSEL_EXT1 = 2'h1;
  localparam logic [1:0]  PMPMC_PSEL_EXT2 = 2'h2;

  // Mode control bit positions.
  localparam int PMPMC_B_SRST = 15;
  localparam int PMPMC_B_LOOP = 14;
  localparam int PMPMC_B_SPD0 = 13;
  localparam int PMPMC_B_ANEN = 12;
  localparam int PMPMC_B_PDN  = 11;
  localparam int PMPMC_B_ANRS = 9;
  localparam int PMPMC_B_DUP  = 8;
  localparam int PMPMC_B_SPD1 = 6;

  // Reset values of the stored mode bits.
  localparam logic PMPMC_RST_LOOP = 1'h0;
  localparam logic PMPMC_RST_SPD0 = 1'h0;
  localparam logic PMPMC_RST_ANEN = 1'h1;
  localparam logic PMPMC_RST_PDN  = 1'h0;
  localparam logic PMPMC_RST_DUP  = 1'h0;
  localparam logic PMPMC_SPD1_RO  = 1'h1;
  localparam logic [15:0] PMPMC_ZERO16 = 16'h0000;

  // Soft reset duration: time in ns and derived cycle count, rounded up.
  localparam int PMPMC_CLK_NS       = 50;
  localparam int PMPMC_SRST_NS      = 1000;
  localparam int PMPMC_SRST_CYCLES  = (PMPMC_SRST_NS + PMPMC_CLK_NS - 1) / PMPMC_CLK_NS;

  // One management request.
  typedef struct packed {
    logic        wr;
    logic [4:0]  idx;
    logic [15:0] wdata;
  } pmpmc_req_type;

  // Stored mode control fields.
  typedef struct packed {
    logic srst;
    logic loop;
    logic spd0;
    logic anen;
    logic pdn;
    logic anrs;
    logic dup;
  } pmpmc_mode_type;

  typedef enum logic [1:0] {
    PMPMC_ST_IDLE = 2'b00,
    PMPMC_ST_ACK  = 2'b01,
    PMPMC_ST_SRST = 2'b10
  } pmpmc_state_type;

endpackage

// ### core/pmpmc_regmem.sv
// Purpose: Small register file holding the plainly stored PHY registers.
// Assumes: One access per cycle, read data registered.
// Notes: Address is {page select, index}.
`timescale 1ns/1ns
module pmpmc_regmem #(
  parameter int AW = 7,
  parameter int DW = 16
) (
  // Clock and reset.
  input  wire logic          i_clk_sys,
  input  wire logic          i_rst,
  // Access port.
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  output logic      [DW-1:0] o_rdata
);

  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] rdata_reg;
  logic [DW-1:0] rdata_next;

  // Read data come out of a register so the answer is aligned with the ack.
  always_comb begin
    rdata_next = mem[i_addr];
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // The array itself has no reset; contents before first write are don't-care.
  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end

  assign o_rdata = rdata_reg;

endmodule

// ### core/pmpmc_top.sv
// Purpose: Mode control register, page decode and management access of the PHY.
// Assumes: Requests are one-cycle strobes from MAC logic on i_clk_sys.
// Notes: A request is taken only while o_mgmt_ready is high.
`timescale 1ns/1ns
module pmpmc_top
  import pmpmc_pkg::*;
#(
  parameter int SRST_CYCLES = PMPMC_SRST_CYCLES
) (
  // Clock and reset.
  input  wire logic          i_clk_sys,
  input  wire logic          i_rst,
  // Management access from the MAC.
  input  wire logic          i_mgmt_req,
  input  wire pmpmc_req_type i_mgmt,
  output logic               o_mgmt_ready,
  output logic               o_mgmt_ack,
  output logic      [15:0]   o_mgmt_rdata,
  // Counter events from the PHY datapath.
  input  wire logic          i_evt_false_carrier,
  input  wire logic          i_evt_link_drop,
  // Mode controls to the PHY core.
  output logic               o_soft_reset,
  output logic               o_loopback,
  output logic               o_power_down,
  output logic               o_an_enable,
  output logic               o_an_restart,
  output logic               o_manual_valid,
  output logic      [1:0]    o_speed_sel,
  output logic               o_full_duplex,
  output logic      [1:0]    o_page_sel
);

  ////////////////////////////////////////////////////////////////////////////
  pmpmc_state_type state_reg, state_next;
  pmpmc_mode_type  mode_reg, mode_next;
  pmpmc_req_type   pend_reg, pend_next;
  logic [1:0]      pend_page_reg, pend_page_next;
  logic            pend_mem_reg, pend_mem_next;
  logic [15:0]     page_reg, page_next;
  logic [15:0]     fix_reg, fix_next;
  logic [15:0]     cnt_q [2];
  logic [15:0]     cnt_reg [2];
  logic [15:0]     cnt_next [2];
  logic [4:0]      srst_cnt_reg, srst_cnt_next;
  logic            take;
  logic [1:0]      psel;
  logic            fixed_hit;
  logic            mem_we;
  logic [6:0]      mem_addr;
  logic [15:0]     mem_q;
  logic [15:0]     mode_word;
  logic [1:0]      evt;

  // Page select decoded from the page access register.
  always_comb begin
    unique case (page_reg)
      PMPMC_PAGE_EXT1: psel = PMPMC_PSEL_EXT1;
      PMPMC_PAGE_EXT2: psel = PMPMC_PSEL_EXT2;
      default:         psel = PMPMC_PSEL_MAIN;
    endcase
  end

  // Reserved bits are tied low and bit 6 is a constant one.
  assign mode_word = {mode_reg.srst, mode_reg.loop, mode_reg.spd0, mode_reg.anen,
                      mode_reg.pdn, 1'b0, mode_reg.anrs, mode_reg.dup, 1'b0,
                      PMPMC_SPD1_RO, 6'h00};

  ////////////////////////////////////////////////////////////////////////////
  // Access decode. Low indices ignore the page; 16-30 follow it.
  assign take = i_mgmt_req && (state_reg == PMPMC_ST_IDLE);
  always_comb begin
    fixed_hit = 1'b0;
    mem_addr  = {PMPMC_PSEL_MAIN, i_mgmt.idx};
    if (i_mgmt.idx >= PMPMC_IDX_EXTLO && i_mgmt.idx != PMPMC_IDX_PAGE) begin
      mem_addr = {psel, i_mgmt.idx};
    end
    if (i_mgmt.idx == PMPMC_IDX_MODE || i_mgmt.idx == PMPMC_IDX_PAGE) begin
      fixed_hit = 1'b1;
    end else if (psel == PMPMC_PSEL_MAIN && (i_mgmt.idx == PMPMC_IDX_FCCNT ||
                 i_mgmt.idx == PMPMC_IDX_LDCNT || i_mgmt.idx == PMPMC_IDX_RSVD)) begin
      fixed_hit = 1'b1;
    end
    // Mask, status, auxiliary and LED registers are plain storage here.
    mem_we = take && i_mgmt.wr && !fixed_hit;
  end

  pmpmc_regmem #(
    .AW (7),
    .DW (16)
  ) u_regmem (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_we      (mem_we),
    .i_addr    (mem_addr),
    .i_wdata   (i_mgmt.wdata),
    .o_rdata   (mem_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Event counters; read-only to management, they wrap on overflow.
  assign evt = {i_evt_link_drop, i_evt_false_carrier};
  for (genvar g = 0; g < 2; g++) begin : g_cnt
    always_comb begin
      cnt_next[g] = evt[g] ? cnt_reg[g] + 16'h0001 : cnt_reg[g];
    end
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
        cnt_reg[g] <= 16'h0000;
      end else begin
        cnt_reg[g] <= cnt_next[g];
      end
    end
    assign cnt_q[g] = cnt_reg[g];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access and soft reset sequencing.
  always_comb begin
    state_next     = state_reg;
    mode_next      = mode_reg;
    pend_next      = pend_reg;
    pend_page_next = pend_page_reg;
    pend_mem_next  = pend_mem_reg;
    page_next      = page_reg;
    fix_next       = fix_reg;
    srst_cnt_next  = srst_cnt_reg;
    mode_next.anrs = 1'b0;
    unique case (state_reg)
      PMPMC_ST_IDLE: begin
        if (take) begin
          state_next     = PMPMC_ST_ACK;
          pend_next      = i_mgmt;
          pend_page_next = psel;
          pend_mem_next  = !fixed_hit;
          unique case (i_mgmt.idx)
            PMPMC_IDX_MODE:  fix_next = mode_word;
            PMPMC_IDX_PAGE:  fix_next = page_reg;
            PMPMC_IDX_FCCNT: fix_next = cnt_q[0];
            PMPMC_IDX_LDCNT: fix_next = cnt_q[1];
            default:         fix_next = PMPMC_ZERO16;
          endcase
          if (i_mgmt.wr && i_mgmt.idx == PMPMC_IDX_PAGE) begin
            page_next = i_mgmt.wdata;
          end
          if (i_mgmt.wr && i_mgmt.idx == PMPMC_IDX_MODE) begin
            mode_next.loop = i_mgmt.wdata[PMPMC_B_LOOP];
            mode_next.spd0 = i_mgmt.wdata[PMPMC_B_SPD0];
            mode_next.anen = i_mgmt.wdata[PMPMC_B_ANEN];
            mode_next.pdn  = i_mgmt.wdata[PMPMC_B_PDN];
            mode_next.anrs = i_mgmt.wdata[PMPMC_B_ANRS];
            mode_next.dup  = i_mgmt.wdata[PMPMC_B_DUP];
          end
        end
      end
      PMPMC_ST_ACK: begin
        state_next = PMPMC_ST_IDLE;
        // A soft reset request is acknowledged first, then the block goes busy.
        if (pend_reg.wr && pend_reg.idx == PMPMC_IDX_MODE &&
            pend_reg.wdata[PMPMC_B_SRST]) begin
          state_next    = PMPMC_ST_SRST;
          mode_next     = '{srst: 1'b1, loop: PMPMC_RST_LOOP, spd0: PMPMC_RST_SPD0,
                            anen: PMPMC_RST_ANEN, pdn: PMPMC_RST_PDN, anrs: 1'b0,
                            dup: PMPMC_RST_DUP};
          srst_cnt_next = 5'(SRST_CYCLES - 1);
        end
      end
      PMPMC_ST_SRST: begin
        if (srst_cnt_reg == 5'h00) begin
          state_next     = PMPMC_ST_IDLE;
          mode_next.srst = 1'b0;
        end else begin
          srst_cnt_next = srst_cnt_reg - 5'h01;
        end
      end
      default: begin
        state_next = PMPMC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_reg     <= PMPMC_ST_IDLE;
      mode_reg      <= '{srst: 1'b0, loop: PMPMC_RST_LOOP, spd0: PMPMC_RST_SPD0,
                         anen: PMPMC_RST_ANEN, pdn: PMPMC_RST_PDN, anrs: 1'b0,
                         dup: PMPMC_RST_DUP};
      pend_reg      <= '0;
      pend_page_reg <= PMPMC_PSEL_MAIN;
      pend_mem_reg  <= 1'b0;
      page_reg      <= PMPMC_PAGE_MAIN;
      fix_reg       <= PMPMC_ZERO16;
      srst_cnt_reg  <= 5'h00;
    end else begin
      state_reg     <= state_next;
      mode_reg      <= mode_next;
      pend_reg      <= pend_next;
      pend_page_reg <= pend_page_next;
      pend_mem_reg  <= pend_mem_next;
      page_reg      <= page_next;
      fix_reg       <= fix_next;
      srst_cnt_reg  <= srst_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs. Read data is a mux of two registers, so it is glitch-free.
  assign o_mgmt_ready   = (state_reg == PMPMC_ST_IDLE);
  assign o_mgmt_ack     = (state_reg == PMPMC_ST_ACK);
  assign o_mgmt_rdata   = !o_mgmt_ack ? PMPMC_ZERO16 : (pend_mem_reg ? mem_q : fix_reg);
  assign o_soft_reset   = mode_reg.srst;
  assign o_loopback     = mode_reg.loop;
  assign o_power_down   = mode_reg.pdn;
  assign o_an_enable    = mode_reg.anen;
  assign o_an_restart   = mode_reg.anrs;
  assign o_manual_valid = !mode_reg.anen;
  assign o_speed_sel    = {PMPMC_SPD1_RO, mode_reg.spd0};
  assign o_full_duplex  = mode_reg.dup;
  assign o_page_sel     = psel;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the behaviour above.
  localparam int A_SRST_M1 = SRST_CYCLES - 1;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence s_take_mode_wr;
    take && i_mgmt.wr && i_mgmt.idx == PMPMC_IDX_MODE && !i_mgmt.wdata[PMPMC_B_SRST];
  endsequence

  sequence s_take_page_clear;
    take && i_mgmt.wr && i_mgmt.idx == PMPMC_IDX_PAGE && i_mgmt.wdata == PMPMC_ZERO16;
  endsequence

  srst_length_a: assert property ($rose(o_soft_reset) |->
    ##A_SRST_M1 o_soft_reset ##1 !o_soft_reset)
    else $error("soft reset length wrong");
  srst_default_a: assert property ($fell(o_soft_reset) |-> o_an_enable &&
    !o_loopback && !o_power_down && !o_full_duplex && o_speed_sel == 2'b10)
    else $error("defaults not restored after soft reset");
  srst_busy_a: assert property (o_soft_reset |-> !o_mgmt_ready && !o_mgmt_ack)
    else $error("access served during soft reset");
  mode_write_a: assert property (s_take_mode_wr |=>
    o_loopback == $past(i_mgmt.wdata[PMPMC_B_LOOP]) &&
    o_power_down == $past(i_mgmt.wdata[PMPMC_B_PDN]) &&
    o_manual_valid == !$past(i_mgmt.wdata[PMPMC_B_ANEN]))
    else $error("mode write not applied");
  an_restart_a: assert property (s_take_mode_wr ##0 i_mgmt.wdata[PMPMC_B_ANRS] |=>
    o_an_restart ##1 !o_an_restart)
    else $error("restart bit not self-clearing");
  mode_read_a: assert property (o_mgmt_ack && !pend_reg.wr &&
    pend_reg.idx == PMPMC_IDX_MODE |-> o_mgmt_rdata[PMPMC_B_SPD1] &&
    o_mgmt_rdata[5:0] == 6'h00 && !o_mgmt_rdata[7] && !o_mgmt_rdata[10])
    else $error("mode read fixed bits wrong");
  page_clear_a: assert property (s_take_page_clear |=> o_page_sel == PMPMC_PSEL_MAIN)
    else $error("page not restored to main");
  rsvd_read_a: assert property (o_mgmt_ack && !pend_reg.wr &&
    pend_reg.idx == PMPMC_IDX_RSVD && pend_page_reg == PMPMC_PSEL_MAIN |->
    o_mgmt_rdata == PMPMC_ZERO16)
    else $error("reserved index not zero");
  ack_timing_a: assert property (take |=> o_mgmt_ack ##1 !o_mgmt_ack)
    else $error("ack not one cycle after request");

endmodule

// ### tb/pmpmc_mac_model.sv
// Purpose: Behavioural MAC management access logic facing the mode control block.
// Assumes: One clock shared with the block; request lines change on the falling edge.
// Notes: Released request fields show the inverted last value, never a stale copy.
`timescale 1ns/1ns
module pmpmc_mac_model
  import pmpmc_pkg::*;
(
  // Clock.
  input  wire logic          i_clk_sys,
  // Answer from the block.
  input  wire logic          i_mgmt_ready,
  input  wire logic          i_mgmt_ack,
  input  wire logic [15:0]   i_mgmt_rdata,
  // Request to the block.
  output logic               o_mgmt_req,
  output pmpmc_req_type      o_mgmt
);
  ////////////////////////////////////////////////////////////////////////////////
  // Request lines idle from time zero.
  initial begin
    o_mgmt_req = 1'b0;
    o_mgmt     = '0;
  end

  // One access: idle gap, bounded wait for ready, one-cycle strobe, then the answer.
  // The wait is bounded so a block stuck in soft reset returns no ack instead of hanging.
  task automatic access(input logic wr_en, input logic [4:0] idx, input logic [15:0] wdata,
                        input int gap, output logic ack, output logic [15:0] rdata);
    int n;
    n = 0;
    repeat (gap) @(negedge i_clk_sys);
    while (i_mgmt_ready !== 1'b1 && n < 200) begin
      @(negedge i_clk_sys);
      n++;
    end
    o_mgmt_req = 1'b1;
    o_mgmt     = '{wr: wr_en, idx: idx, wdata: wdata};
    @(negedge i_clk_sys);
    ack        = i_mgmt_ack;
    rdata      = i_mgmt_rdata;
    o_mgmt_req = 1'b0;
    o_mgmt     = ~o_mgmt;
  endtask
endmodule

// ### tb/pmpmc_tb.sv
// Purpose: Self-checking bench for the mode control register set.
// Assumes: Inputs change on the falling edge; the soft reset length is the package default.
// Notes: Plain storage has no reset value, so it is always written before it is read.
`timescale 1ns/1ns
module testbench
  import pmpmc_pkg::*;
;
  logic          i_clk_sys;
  logic          i_rst;
  logic          i_mgmt_req;
  pmpmc_req_type i_mgmt;
  logic          o_mgmt_ready;
  logic          o_mgmt_ack;
  logic [15:0]   o_mgmt_rdata;
  logic          i_evt_false_carrier;
  logic          i_evt_link_drop;
  logic          o_soft_reset;
  logic          o_loopback;
  logic          o_power_down;
  logic          o_an_enable;
  logic          o_an_restart;
  logic          o_manual_valid;
  logic [1:0]    o_speed_sel;
  logic          o_full_duplex;
  logic [1:0]    o_page_sel;
  int            err_total;
  int            checks;
  int            cycles;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, reset and event inputs from time zero.
  initial begin
    i_clk_sys           = 1'b0;
    i_rst               = 1'b1;
    i_evt_false_carrier = 1'b0;
    i_evt_link_drop     = 1'b0;
    err_total           = 0;
    checks              = 0;
    cycles              = 0;
  end
  always #25 i_clk_sys = ~i_clk_sys;

  // Cycle ceiling: the whole sequence needs well under two thousand cycles.
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  pmpmc_top u_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_mgmt_req(i_mgmt_req),
    .i_mgmt(i_mgmt), .o_mgmt_ready(o_mgmt_ready), .o_mgmt_ack(o_mgmt_ack),
    .o_mgmt_rdata(o_mgmt_rdata), .i_evt_false_carrier(i_evt_false_carrier),
    .i_evt_link_drop(i_evt_link_drop), .o_soft_reset(o_soft_reset), .o_loopback(o_loopback),
    .o_power_down(o_power_down), .o_an_enable(o_an_enable), .o_an_restart(o_an_restart),
    .o_manual_valid(o_manual_valid), .o_speed_sel(o_speed_sel),
    .o_full_duplex(o_full_duplex), .o_page_sel(o_page_sel));

  pmpmc_mac_model u_mac (.i_clk_sys(i_clk_sys), .i_mgmt_ready(o_mgmt_ready),
    .i_mgmt_ack(o_mgmt_ack), .i_mgmt_rdata(o_mgmt_rdata), .o_mgmt_req(i_mgmt_req),
    .o_mgmt(i_mgmt));

  ////////////////////////////////////////////////////////////////////////////////
  // Shared comparison, counts every call.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Write and read through the management model; both expect an ack.
  task automatic wr(input logic [4:0] idx, input logic [15:0] d);
    logic        a;
    logic [15:0] r;
    u_mac.access(1'b1, idx, d, 0, a, r);
    check(16'(a), 16'h0001, "write ack");
  endtask

  task automatic rd(input logic [4:0] idx, input logic [15:0] exp, input string what);
    logic        a;
    logic [15:0] r;
    u_mac.access(1'b0, idx, 16'h0000, 1, a, r);
    check(16'(a), 16'h0001, "read ack");
    check(r, exp, what);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Defaults, reserved bits and the read-only speed bit.
  task automatic t_manual();
    logic [15:0] d;
    check(16'({o_an_enable, o_speed_sel, o_manual_valid}), 16'h000c, "reset outs");
    rd(5'h00, 16'h1040, "mode default");
    wr(5'h00, 16'h64bf);
    rd(5'h00, 16'h6040, "reserved ignored");
    check(16'(o_loopback), 16'h0001, "loopback on");
    // Walk both duplex values and both writable speed codes with negotiation off.
    for (int k = 0; k < 4; k++) begin
      d = (k[0] ? 16'h2000 : 16'h0000) | (k[1] ? 16'h0100 : 16'h0000);
      wr(5'h00, d);
      check(16'({o_speed_sel, o_full_duplex}), 16'(k[1] | 4 | (k[0] << 1)), "manual");
      check(16'({o_manual_valid, o_loopback}), 16'h0002, "manual valid");
    end
    $display("test manual done");
  endtask

  // Negotiation overrides manual bits, restart self-clears, power down round trip.
  task automatic t_an_pdn();
    wr(5'h00, 16'h3100);
    check(16'({o_manual_valid, o_an_enable}), 16'h0001, "an override");
    rd(5'h00, 16'h3140, "an readback");
    wr(5'h00, 16'h1200);
    check(16'(o_an_restart), 16'h0001, "restart pulse");
    @(negedge i_clk_sys);
    check(16'(o_an_restart), 16'h0000, "restart end");
    rd(5'h00, 16'h1040, "restart cleared");
    wr(5'h00, 16'h0000);
    wr(5'h00, 16'h0800);
    check(16'({o_power_down, o_an_enable}), 16'h0002, "power down");
    rd(5'h00, 16'h0840, "pdn readback");
    wr(5'h00, 16'h1000);
    check(16'(o_power_down), 16'h0000, "power up");
    $display("test an_pdn done");
  endtask

  // Page switching redirects index 16 but not index 0 or 31.
  task automatic t_pages();
    wr(5'h10, 16'h0a0a);
    wr(5'h1f, 16'h0001);
    check(16'(o_page_sel), 16'h0001, "page 1");
    wr(5'h10, 16'h1111);
    rd(5'h00, 16'h1040, "mode on page 1");
    wr(5'h1f, 16'h0002);
    check(16'(o_page_sel), 16'h0002, "page 2");
    wr(5'h10, 16'h2222);
    rd(5'h00, 16'h1040, "mode on page 2");
    rd(5'h1f, 16'h0002, "page readback");
    rd(5'h10, 16'h2222, "page 2 store");
    wr(5'h1f, 16'h0001);
    rd(5'h10, 16'h1111, "page 1 store");
    wr(5'h1f, 16'h0000);
    check(16'(o_page_sel), 16'h0000, "main page");
    rd(5'h10, 16'h0a0a, "main store");
    $display("test pages done");
  endtask

  // Counters, reserved index and the decoded storage registers of the main page.
  task automatic t_decode();
    logic        a;
    logic [15:0] fc;
    logic [15:0] ld;
    u_mac.access(1'b0, 5'h14, 16'h0000, 0, a, fc);
    u_mac.access(1'b0, 5'h15, 16'h0000, 0, a, ld);
    for (int k = 0; k < 3; k++) begin
      @(negedge i_clk_sys);
      i_evt_false_carrier = 1'b1;
      i_evt_link_drop     = (k < 2);
      @(negedge i_clk_sys);
      i_evt_false_carrier = 1'b0;
      i_evt_link_drop     = 1'b0;
    end
    wr(5'h14, 16'h5555);
    rd(5'h14, fc + 16'h0003, "false carrier");
    rd(5'h15, ld + 16'h0002, "link drop");
    wr(5'h1b, 16'hffff);
    rd(5'h1b, 16'h0000, "reserved index");
    for (int i = 22; i < 31; i++) if (i != 27) wr(5'(i), 16'h5a00 | 16'(i));
    for (int i = 22; i < 31; i++) if (i != 27) rd(5'(i), 16'h5a00 | 16'(i), "store");
    $display("test decode done");
  endtask

  // Soft reset length, defaults restored, access held off meanwhile.
  task automatic t_srst();
    int n;
    n = 0;
    wr(5'h00, 16'h4100);
    wr(5'h00, 16'h8000);
    @(negedge i_clk_sys);
    check(16'({o_soft_reset, o_mgmt_ready}), 16'h0002, "srst start");
    check(16'({o_loopback, o_an_enable, o_full_duplex}), 16'h0002, "srst dflt");
    while (o_soft_reset === 1'b1 && n < 100) begin
      @(negedge i_clk_sys);
      n++;
    end
    check(16'(n), 16'(PMPMC_SRST_CYCLES), "srst length");
    rd(5'h00, 16'h1040, "after srst");
    $display("test srst done");
  endtask

  // A reset in mid-run must put the mode bits and the page select back to defaults.
  task automatic t_rst();
    wr(5'h00, 16'h4000);
    wr(5'h1f, 16'h0002);
    @(negedge i_clk_sys);
    i_rst = 1'b1;
    @(negedge i_clk_sys);
    i_rst = 1'b0;
    check(16'({o_loopback, o_an_enable, o_page_sel}), 16'h0004, "reset dflt");
    rd(5'h00, 16'h1040, "after reset");
    $display("test rst done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Counts and verdict, then end of run.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (20) @(negedge i_clk_sys);
    i_rst = 1'b0;
    t_manual();
    t_an_pdn();
    t_pages();
    t_decode();
    t_srst();
    t_rst();
    report_and_stop();
  end
endmodule
